// ===== hw/acp_defines.svh
`ifndef ACP_DEFINES_SVH
`define ACP_DEFINES_SVH
`define ACP_CLK_MHZ 40
`define ACP_LAST_BIT 4'hF
`define ACP_RESULT_MSB 4'hD
`define ACP_RESULT_BITS 4'hE
`define ACP_CMD_CFG_WRITE 4'hA
`define ACP_CMD_TEST_MID 4'hB
`define ACP_CMD_TEST_LOW 4'hC
`define ACP_CMD_TEST_HIGH 4'hD
`define ACP_CHAN_LAST 4'h7
`define ACP_CFG_RESET 16'h0000
`define ACP_HW_CONFIG 16'h0800
`define ACP_HW_INIT_WORD 16'hFFFF
`define ACP_CFG_SCLK_CONV 10
`define ACP_CFG_INT_MODE 9
`define ACP_INIT_FRAMES 2'h2
`define ACP_SAMPLE_NS 1000
`define ACP_CONV_NS 2800
`define ACP_SAMPLE_CYC ((`ACP_SAMPLE_NS * `ACP_CLK_MHZ + 999) / 1000)
`define ACP_CONV_CYC ((`ACP_CONV_NS * `ACP_CLK_MHZ) / 1000)
`define ACP_CONV_SCLK_TICKS 14
`define ACP_CODE_MID 14'h2000
`define ACP_CODE_LOW 14'h0000
`define ACP_CODE_HIGH 14'h3FFF
`define ACP_SYNC_IDLE 5'h07
`endif

// ===== hw/acp_pkg.sv
package acp_pkg;
   typedef enum logic [3:0] {
      ACP_IDLE = 4'h1,
      ACP_SAMPLE = 4'h2,
      ACP_HOLD = 4'h4,
      ACP_CONVERT = 4'h8
   } acp_state_t;
   typedef enum logic [1:0] {
      ACP_SRC_CHAN = 2'h0,
      ACP_SRC_MID = 2'h1,
      ACP_SRC_LOW = 2'h2,
      ACP_SRC_HIGH = 2'h3
   } acp_src_t;
endpackage

// ===== hw/acp_serial_port.sv
// Summary of operation
// - Chip select high: output off, input ignored.
// - Chip select rise clears counter; fall drives output.
// - Input frame is 16 bits, MSB first.
// - Top nibble 1010b writes configuration register.
// - Input bits captured on rising serial clock.
// - Top nibble selects mode; low 12 ignored unless 1010b or an all-ones init frame.
// - Output carries previous 14-bit result, MSB first.
// - MSB appears as soon as chip select falls.
// - Later output bits advance on rising clock.
// - Serial clock optionally clocks the conversion.
// - Start low samples; its rise starts conversion.
// - Sync low at select fall: start on rise.
// - Status as busy: low during conversion.
// - Status as interrupt: low after completion.
// - Frame sync rise also clears interrupt status.
// - Reset: status high, results cleared, init count restarts.
// - Two all-ones init frames load hardware config.
// - Words 0000h to 7000h select input channel.
// - Words B000h, C000h, D000h select self tests.
`include "acp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module acp_serial_port
   import acp_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic sclk,
   input wire logic csN,
   input wire logic sdi,
   output logic sdoOut,
   output logic sdoOeN,
   input wire logic frameSyncIn,
   input wire logic conversionStartN,
   input wire logic [13:0] analogCode,
   output logic [2:0] chanSel,
   output logic statusN,
   output logic [15:0] configRegister,
   output logic hwMode
);

   // Reset release in the core domain.
   logic rstMeta_reg;
   logic rstN_reg;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rstMeta_reg <= 1'b0;
         rstN_reg <= 1'b0;
      end else begin
         rstMeta_reg <= 1'b1;
         rstN_reg <= rstMeta_reg;
      end
   end

   // Link side: shift logic runs on the host serial clock and is held in
   // reset by chip select, so a deselected port never sees clock edges.
   logic [3:0] bitCount_reg;
   logic frameDone_reg;
   logic [15:0] rxShift_reg;
   logic [15:0] rxWord_reg;
   logic rxToggle_reg;
   logic tickToggle_reg;
   logic [13:0] outWord_reg;

   always_ff @(posedge sclk or posedge csN) begin
      if (csN) begin
         bitCount_reg <= '0;
         frameDone_reg <= 1'b0;
         rxShift_reg <= '0;
      end else begin
         rxShift_reg <= {rxShift_reg[14:0], sdi};
         bitCount_reg <= bitCount_reg + 4'h1;
         if (bitCount_reg == `ACP_LAST_BIT) begin
            frameDone_reg <= 1'b1;
         end
      end
   end

   // The word register is not reset by chip select: the toggle that tells
   // the core a word is ready must never flip on deselect.
   always_ff @(posedge sclk or negedge resetn) begin
      if (!resetn) begin
         rxWord_reg <= '0;
         rxToggle_reg <= 1'b0;
         tickToggle_reg <= 1'b0;
      end else if (!csN) begin
         tickToggle_reg <= ~tickToggle_reg;
         if (bitCount_reg == `ACP_LAST_BIT && !frameDone_reg) begin
            rxWord_reg <= {rxShift_reg[14:0], sdi};
            rxToggle_reg <= ~rxToggle_reg;
         end
      end
   end

   // The result word only changes while chip select is high, so it is
   // stable for the whole frame that reads it through this mux.
   always_comb begin
      sdoOeN = csN;
      sdoOut = 1'b0;
      if (!frameDone_reg && bitCount_reg < `ACP_RESULT_BITS) begin
         sdoOut = outWord_reg[`ACP_RESULT_MSB - bitCount_reg];
      end
   end

   // Core side synchronisers: the first stage feeds only the second.
   // Pins idle high and the toggles reset low, so reset makes no event.
   logic [4:0] syncA_reg;
   logic [4:0] syncB_reg;
   logic [4:0] syncC_reg;
   logic [4:0] pinBundle;

   assign pinBundle = {tickToggle_reg, rxToggle_reg, conversionStartN,
                       frameSyncIn, csN};

   always_ff @(posedge core_clk or negedge rstN_reg) begin
      if (!rstN_reg) begin
         syncA_reg <= `ACP_SYNC_IDLE;
         syncB_reg <= `ACP_SYNC_IDLE;
         syncC_reg <= `ACP_SYNC_IDLE;
      end else begin
         syncA_reg <= pinBundle;
         syncB_reg <= syncA_reg;
         syncC_reg <= syncB_reg;
      end
   end

   logic csS;
   logic fsS;
   logic startS;
   logic csFall;
   logic fsRise;
   logic startFall;
   logic startRise;
   logic wordValid;
   logic convTick;

   assign csS = syncB_reg[0];
   assign fsS = syncB_reg[1];
   assign startS = syncB_reg[2];
   assign csFall = syncC_reg[0] && !syncB_reg[0];
   assign fsRise = !syncC_reg[1] && syncB_reg[1];
   assign startFall = syncC_reg[2] && !syncB_reg[2];
   assign startRise = !syncC_reg[2] && syncB_reg[2];
   assign wordValid = syncC_reg[3] != syncB_reg[3];
   assign convTick = syncC_reg[4] != syncB_reg[4];

   // Initialisation frames and configuration.
   logic [1:0] initCount_reg;
   logic initOnes_reg;
   logic [15:0] config_reg;
   logic hwMode_reg;
   logic [3:0] command;

   assign command = rxWord_reg[15:12];

   always_ff @(posedge core_clk or negedge rstN_reg) begin
      if (!rstN_reg) begin
         initCount_reg <= '0;
         initOnes_reg <= 1'b1;
         config_reg <= `ACP_CFG_RESET;
         hwMode_reg <= 1'b0;
      end else if (wordValid) begin
         if (initCount_reg != `ACP_INIT_FRAMES) begin
            initCount_reg <= initCount_reg + 2'h1;
            initOnes_reg <= initOnes_reg &&
                            rxWord_reg == `ACP_HW_INIT_WORD;
         end
         if (initCount_reg == `ACP_INIT_FRAMES - 2'h1 && initOnes_reg &&
             rxWord_reg == `ACP_HW_INIT_WORD) begin
            config_reg <= `ACP_HW_CONFIG;
            hwMode_reg <= 1'b1;
         end else if (command == `ACP_CMD_CFG_WRITE) begin
            config_reg <= {4'h0, rxWord_reg[11:0]};
         end
      end
   end

   // Channel and self-test selection; other commands are left alone.
   logic [2:0] chan_reg;
   acp_src_t src_reg;

   always_ff @(posedge core_clk or negedge rstN_reg) begin
      if (!rstN_reg) begin
         chan_reg <= '0;
         src_reg <= ACP_SRC_CHAN;
      end else if (wordValid && initCount_reg == `ACP_INIT_FRAMES) begin
         if (command <= `ACP_CHAN_LAST) begin
            chan_reg <= command[2:0];
            src_reg <= ACP_SRC_CHAN;
         end else if (command == `ACP_CMD_TEST_MID) begin
            src_reg <= ACP_SRC_MID;
         end else if (command == `ACP_CMD_TEST_LOW) begin
            src_reg <= ACP_SRC_LOW;
         end else if (command == `ACP_CMD_TEST_HIGH) begin
            src_reg <= ACP_SRC_HIGH;
         end
      end
   end

   // Conversion sequencer.
   acp_state_t state_reg;
   logic [7:0] count_reg;
   logic fsArm_reg;
   logic convDone;
   logic sclkConv;

   assign sclkConv = config_reg[`ACP_CFG_SCLK_CONV];

   always_ff @(posedge core_clk or negedge rstN_reg) begin
      if (!rstN_reg) begin
         fsArm_reg <= 1'b0;
      end else if (csFall && !fsS) begin
         fsArm_reg <= 1'b1;
      end else if (fsRise || csS) begin
         fsArm_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rstN_reg) begin
      if (!rstN_reg) begin
         state_reg <= ACP_IDLE;
         count_reg <= '0;
      end else begin
         case (state_reg)
            ACP_IDLE: begin
               count_reg <= '0;
               if (!startS) begin
                  state_reg <= ACP_HOLD;
               end else if (fsArm_reg && fsRise) begin
                  state_reg <= ACP_SAMPLE;
               end else if (csFall && fsS) begin
                  state_reg <= ACP_SAMPLE;
               end
            end
            ACP_SAMPLE: begin
               count_reg <= count_reg + 8'h1;
               if (count_reg == 8'(`ACP_SAMPLE_CYC - 1)) begin
                  count_reg <= '0;
                  state_reg <= ACP_CONVERT;
               end
            end
            ACP_HOLD: begin
               if (startRise) begin
                  state_reg <= ACP_CONVERT;
               end
            end
            ACP_CONVERT: begin
               if (!sclkConv || convTick) begin
                  count_reg <= count_reg + 8'h1;
               end
               if (convDone) begin
                  count_reg <= '0;
                  state_reg <= ACP_IDLE;
               end
            end
            default: begin
               state_reg <= ACP_IDLE;
            end
         endcase
      end
   end

   // With the serial clock as conversion clock a stopped burst simply
   // stretches the conversion; nothing special has to be configured.
   always_comb begin
      convDone = 1'b0;
      if (state_reg == ACP_CONVERT) begin
         if (sclkConv) begin
            convDone = convTick &&
                       count_reg == 8'(`ACP_CONV_SCLK_TICKS - 1);
         end else begin
            convDone = count_reg == 8'(`ACP_CONV_CYC - 1);
         end
      end
   end

   // Results.
   logic [13:0] result_reg;
   logic [13:0] srcCode;

   always_comb begin
      case (src_reg)
         ACP_SRC_MID: srcCode = `ACP_CODE_MID;
         ACP_SRC_LOW: srcCode = `ACP_CODE_LOW;
         ACP_SRC_HIGH: srcCode = `ACP_CODE_HIGH;
         default: srcCode = analogCode;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstN_reg) begin
      if (!rstN_reg) begin
         result_reg <= '0;
      end else if (convDone) begin
         result_reg <= srcCode;
      end
   end

   always_ff @(posedge core_clk or negedge rstN_reg) begin
      if (!rstN_reg) begin
         outWord_reg <= '0;
      end else if (csS && syncC_reg[0]) begin
         outWord_reg <= result_reg;
      end
   end

   // Status pin; in interrupt mode a completion in the clearing cycle keeps the pin low.
   logic intFlag_reg;
   logic intMode;

   assign intMode = config_reg[`ACP_CFG_INT_MODE];

   always_ff @(posedge core_clk or negedge rstN_reg) begin
      if (!rstN_reg) begin
         intFlag_reg <= 1'b0;
      end else if (convDone) begin
         intFlag_reg <= 1'b1;
      end else if (csFall || startFall || fsRise) begin
         intFlag_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rstN_reg) begin
      if (!rstN_reg) begin
         statusN <= 1'b1;
      end else if (intMode) begin
         statusN <= !(intFlag_reg || convDone);
      end else begin
         statusN <= !(state_reg == ACP_CONVERT && !convDone);
      end
   end

   assign chanSel = chan_reg;
   assign configRegister = config_reg;
   assign hwMode = hwMode_reg;

endmodule
`default_nettype wire

// ===== bench/acp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module acp_host_model (
   input wire logic sdoOut,
   output logic csN,
   output logic sclk,
   output logic sdi
);
   initial begin
      csN = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   // The clock only runs inside a frame, as a burst-mode host does it.
   task automatic frame(input logic [15:0] w, output logic [15:0] rx);
      csN = 1'b0;
      sdi = w[15];
      #16;
      rx[15] = sdoOut;
      for (int i = 15; i >= 0; i--) begin
         sclk = 1'b1;
         #16;
         sclk = 1'b0;
         if (i > 0) begin
            rx[i - 1] = sdoOut;
            sdi = w[i - 1];
         end
         #16;
      end
      // Select stays low past the sampling window, or the result is lost.
      #797;
      csN = 1'b1;
      sdi = ~sdi;
   endtask
endmodule
`default_nettype wire

// ===== bench/acp_serial_port_assertions.sv
`include "acp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module acp_port_checker (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic csN,
   input wire logic sdoOeN,
   input wire logic frameSyncIn,
   input wire logic conversionStartN,
   input wire logic statusN,
   input wire logic [15:0] configRegister,
   input wire logic hwMode
);
   localparam int intBit = `ACP_CFG_INT_MODE;
   localparam int clkBit = `ACP_CFG_SCLK_CONV;
   logic [3:0] quiet;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Pin edges need time to pass the synchronisers before they may act.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         quiet <= 4'h0;
      else if (!csN || !conversionStartN || !frameSyncIn)
         quiet <= 4'h0;
      else if (quiet != 4'hF)
         quiet <= quiet + 4'h1;
   end
   chk_oe_follow: assert property (
      sdoOeN == csN) else $error("oe differs from csN");
   chk_reset_vals: assert property (
      $rose(resetn) |-> statusN && configRegister == 16'h0000 && !hwMode)
      else $error("bad reset value");
   chk_eoc_width: assert property (
      $fell(statusN) && !configRegister[intBit] && !configRegister[clkBit]
      |-> (!statusN throughout ##96 1) ##[1:30] statusN)
      else $error("busy width wrong");
   chk_int_cs: assert property (
      configRegister[intBit] && !statusN && $fell(csN) |-> ##[1:6] statusN)
      else $error("int not cleared by csN");
   chk_int_fs: assert property (
      configRegister[intBit] && !statusN && $rose(frameSyncIn)
      |-> ##[1:6] statusN) else $error("int not cleared by sync");
   chk_int_hold: assert property (
      configRegister[intBit] && !statusN && quiet == 4'hF |=> !statusN)
      else $error("int dropped");
   chk_start_conv: assert property (
      !configRegister[intBit] && $rose(conversionStartN)
      |-> ##[1:6] !statusN) else $error("no convert on start rise");
   chk_hw_config: assert property (
      $rose(hwMode) |-> configRegister == 16'h0800) else $error("hw config");
   cover property ($rose(hwMode));
   cover property (configRegister[intBit] && $fell(statusN));
   cover property ($rose(conversionStartN) && statusN);
endmodule
bind acp_serial_port acp_port_checker i_chk (
   .core_clk(core_clk),
   .resetn(resetn),
   .csN(csN),
   .sdoOeN(sdoOeN),
   .frameSyncIn(frameSyncIn),
   .conversionStartN(conversionStartN),
   .statusN(statusN),
   .configRegister(configRegister),
   .hwMode(hwMode)
);
`default_nettype wire

// ===== bench/adc_serial_control_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adc_serial_control_port_tb_top;
   logic core_clk;
   logic resetn;
   logic sclk;
   logic csN;
   logic sdi;
   logic sdoOut;
   logic sdoOeN;
   logic frameSyncIn;
   logic conversionStartN;
   logic [13:0] analogCode;
   logic [2:0] chanSel;
   logic statusN;
   logic [15:0] configRegister;
   logic hwMode;
   logic [15:0] rx;
   logic [3:0] c;
   logic [13:0] expQ[$];
   logic [3:0] cmds[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
      4'hB, 4'hC, 4'hD};
   int fail_count = 0;
   int n_checks = 0;
   int n;
   acp_serial_port i_dut (
      .core_clk(core_clk),
      .resetn(resetn),
      .sclk(sclk),
      .csN(csN),
      .sdi(sdi),
      .sdoOut(sdoOut),
      .sdoOeN(sdoOeN),
      .frameSyncIn(frameSyncIn),
      .conversionStartN(conversionStartN),
      .analogCode(analogCode),
      .chanSel(chanSel),
      .statusN(statusN),
      .configRegister(configRegister),
      .hwMode(hwMode)
   );
   acp_host_model i_host (
      .sdoOut(sdoOut),
      .csN(csN),
      .sclk(sclk),
      .sdi(sdi)
   );
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
      #2;
   endtask
   task automatic wait_st(input logic lv);
      n = 0;
      while (statusN !== lv && n < 400) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic xfer(input logic [15:0] w, input int gap);
      i_host.frame(w, rx);
      cyc(gap);
   endtask
   task automatic do_reset();
      resetn = 1'b0;
      cyc(2);
      resetn = 1'b1;
      cyc(5);
      chk("statusN", 16'(statusN), 16'h0001);
      chk("chanSel", 16'(chanSel), 16'h0000);
   endtask
   function automatic logic [13:0] code_of(input logic [3:0] k);
      case (k)
         4'hB: return 14'h2000;
         4'hC: return 14'h0000;
         4'hD: return 14'h3FFF;
         default: return analogCode;
      endcase
   endfunction
   initial begin
      cyc(30000);
      fail_count++;
      $display("[ERR] watchdog expected done seen hang");
      stop_test();
   end
   initial begin
      resetn = 1'b0;
      frameSyncIn = 1'b1;
      conversionStartN = 1'b1;
      analogCode = 14'h0000;
      n = $urandom(32'h8354_1197);
      do_reset();
      xfer(16'hFFFF, 200);
      xfer(16'hFFFF, 10);
      chk("configRegister", configRegister, 16'h0800);
      chk("hwMode", 16'(hwMode), 16'h0001);
      do_reset();
      xfer(16'hA000, 200);
      xfer(16'hA000, 200);
      chk("configRegister", configRegister, 16'h0000);
      // Each command goes out twice, so the read holds its code either way.
      for (int j = 0; j < 23; j++) begin
         c = (j < 22) ? cmds[j / 2] : 4'h0;
         if (j % 2 == 0)
            analogCode = 14'($urandom);
         xfer({c, 12'($urandom)}, 200);
         if (j > 1 && j % 2 == 0)
            chk("sdo", rx, {expQ.pop_front(), 2'b00});
         if (j % 2 == 1)
            expQ.push_back(code_of(c));
         if (j % 2 == 1 && c < 4'h8)
            chk("chanSel", 16'(chanSel), 16'(c));
      end
      conversionStartN = 1'b0;
      cyc(50);
      chk("statusN", 16'(statusN), 16'h0001);
      conversionStartN = 1'b1;
      cyc(6);
      chk("statusN", 16'(statusN), 16'h0000);
      wait_st(1'b1);
      chk("busyWidth", 16'(n > 99 && n < 112), 16'h0001);
      // A stopped burst leaves the conversion waiting for the next frame.
      xfer(16'hA400, 200);
      chk("configRegister", configRegister, 16'h0400);
      chk("statusN", 16'(statusN), 16'h0000);
      xfer(16'h1000, 200);
      chk("statusN", 16'(statusN), 16'h0001);
      xfer(16'hA200, 200);
      xfer(16'hA200, 200);
      chk("configRegister", configRegister, 16'h0200);
      xfer(16'h1000, 1);
      wait_st(1'b0);
      cyc(40);
      chk("statusN", 16'(statusN), 16'h0000);
      frameSyncIn = 1'b0;
      cyc(4);
      frameSyncIn = 1'b1;
      cyc(8);
      chk("statusN", 16'(statusN), 16'h0001);
      frameSyncIn = 1'b0;
      // Sync rises while select is still low, so the sampling stays framed.
      fork
         i_host.frame(16'h1000, rx);
         begin
            cyc(4);
            chk("statusN", 16'(statusN), 16'h0001);
            frameSyncIn = 1'b1;
            wait_st(1'b0);
            chk("fsDelay", 16'(n > 152 && n < 159), 16'h0001);
         end
      join
      chk("statusN", 16'(statusN), 16'h0000);
      xfer(16'h1000, 1);
      chk("statusN", 16'(statusN), 16'h0001);
      cyc(200);
      stop_test();
   end
endmodule
`default_nettype wire
